// file: rtl/lrd_defines.svh
// Timing figures and pin encodings for the link interface reset and disable block.
// Assumes the system clock runs at 125 MHz; all counts derive from the period below.
`ifndef LRD_DEFINES_SVH
`define LRD_DEFINES_SVH

`define LRD_CLK_PERIOD_NS 8

// Pulse phase limits the controller keeps, in ns.
`define LRD_PULSE_LOW_NS 2600
`define LRD_PULSE_HIGH_NS 2600

// Recognition deadlines, in ns; longest times, so they round down.
`define LRD_RESET_RECOG_NS 2680
`define LRD_DISABLE_RECOG_NS 26110
`define LRD_RESET_RECOG_CYC (`LRD_RESET_RECOG_NS / `LRD_CLK_PERIOD_NS)
`define LRD_DISABLE_RECOG_CYC (`LRD_DISABLE_RECOG_NS / `LRD_CLK_PERIOD_NS)

// Cycles lost in the input synchroniser and the threshold compare.
`define LRD_DETECT_PIPE_CYC 3
`define LRD_RESET_THR (`LRD_RESET_RECOG_CYC - `LRD_DETECT_PIPE_CYC)
`define LRD_DISABLE_THR (`LRD_DISABLE_RECOG_CYC - `LRD_DETECT_PIPE_CYC)
`define LRD_WATCH_W 12

// Clock restart from low power, in ns; the least time rounds up.
`define LRD_WAKE_MIN_NS 5300000
`define LRD_WAKE_MAX_NS 7300000
`define LRD_WAKE_MIN_CYC ((`LRD_WAKE_MIN_NS + `LRD_CLK_PERIOD_NS - 1) / `LRD_CLK_PERIOD_NS)
`define LRD_WAKE_W 20

// Initialisation: receive is shown on the eighth interface clock cycle.
`define LRD_INIT_LAST 3'h7

// Control line states and data values driven by this end.
`define LRD_CONTROL_IDLE 2'h0
`define LRD_CONTROL_RECEIVE 2'h2
`define LRD_DATA_ZERO 8'h00
`define LRD_DATA_ON 8'hFF

`endif

// file: rtl/lrd_pkg.sv
// Types shared by the link interface reset and disable block.
// Assumes lrd_defines.svh supplies every number.
package lrd_pkg;

   typedef enum logic [2:0] {
      LRD_ST_DISABLED, LRD_ST_WAKE, LRD_ST_INIT, LRD_ST_NORMAL, LRD_ST_RESET
   } lrd_state_e;

   typedef enum logic [1:0] {
      LRD_LK_OFF, LRD_LK_INIT, LRD_LK_RECV, LRD_LK_RUN
   } lrd_link_e;

endpackage : lrd_pkg

// file: rtl/lrd_sync.sv
// Two-stage synchroniser for one level.
// Assumes the input is a level that holds for at least two destination cycles.
`timescale 1ns/1ps
module lrd_sync (
   // Destination clock
   input wire logic clk,
   // Level in and out
   input wire logic din,
   output logic dout
);

   logic meta;

   // The first stage feeds only the second; nothing else reads it.
   always_ff @(posedge clk) begin
      meta <= din;
      dout <= meta;
   end

endmodule : lrd_sync

// file: rtl/lrd_activity.sv
// Inactivity timer on the synchronised link power status line.
// Assumes the input is already synchronised to clk.
`timescale 1ns/1ps
`include "lrd_defines.svh"
module lrd_activity (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Synchronised status line
   input wire logic pwr_stat,
   // Inactivity flags
   output logic reset_seen,
   output logic disable_seen
);

   logic [`LRD_WATCH_W-1:0] idle_cnt;

   // Any high phase counts as a pulse, so level and pulsed lines share one path.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         idle_cnt <= '0;
      end else if (pwr_stat) begin
         idle_cnt <= '0;
      end else if (idle_cnt != `LRD_WATCH_W'(`LRD_DISABLE_THR)) begin
         idle_cnt <= idle_cnt + `LRD_WATCH_W'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         reset_seen <= 1'b0;
         disable_seen <= 1'b0;
      end else begin
         reset_seen <= !pwr_stat && idle_cnt >= `LRD_WATCH_W'(`LRD_RESET_THR);
         disable_seen <= !pwr_stat && idle_cnt >= `LRD_WATCH_W'(`LRD_DISABLE_THR);
      end
   end

endmodule : lrd_activity

// file: rtl/lrd_top.sv
// Reset and disable control of the parallel link interface, physical layer end.
// Assumes clk is the free-running 125 MHz system clock and link_clk the interface clock source.
`timescale 1ns/1ps
`include "lrd_defines.svh"
module lrd_top
   import lrd_pkg::*;
#(
   parameter int WAKE_CYCLES = `LRD_WAKE_MIN_CYC
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic link_clk,
   input wire logic nrst,
   // Link pins in
   input wire logic link_power_status,
   input wire logic link_request_line,
   input wire logic iso_mode,
   // Link pins out
   output logic [1:0] control_lines_out,
   output logic control_lines_oe,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic interface_clock_out,
   output logic interface_clock_oe,
   // Core side on clk
   input wire logic ports_active,
   input wire logic status_pending,
   output logic iface_ready,
   output logic iface_reset,
   output logic iface_disabled,
   output logic low_power,
   output logic status_discard,
   // Core side on link_clk
   output logic link_request_seen,
   output logic request_cancel
);

   // ---------------------------------------------------------------
   // System clock domain.
   // ---------------------------------------------------------------

   lrd_state_e state;
   lrd_state_e next_state;
   logic pwr_stat_s;
   logic reset_seen;
   logic disable_seen;
   logic link_ready_s;
   logic link_ready;
   logic [`LRD_WAKE_W-1:0] wake_cnt;
   logic wake_done;
   logic clock_run;
   logic iface_on;

   // The status pin comes from the controller, possibly across a barrier.
   lrd_sync u_sync_pwr (
      .clk(clk),
      .din(link_power_status),
      .dout(pwr_stat_s)
   );

   lrd_activity u_watch (
      .clk(clk),
      .nrst(nrst),
      .pwr_stat(pwr_stat_s),
      .reset_seen(reset_seen),
      .disable_seen(disable_seen)
   );

   // The link side reports completion of its initialisation sequence.
   lrd_sync u_sync_ready (
      .clk(clk),
      .din(link_ready),
      .dout(link_ready_s)
   );

   assign wake_done = wake_cnt == `LRD_WAKE_W'(WAKE_CYCLES - 1);

   always_comb begin
      next_state = state;
      case (state)
         LRD_ST_DISABLED: begin
            if (pwr_stat_s) begin
               // Coming out of low power the oscillator needs its settling time.
               next_state = low_power ? LRD_ST_WAKE : LRD_ST_INIT;
            end
         end
         LRD_ST_WAKE: begin
            if (wake_done) begin
               next_state = LRD_ST_INIT;
            end
         end
         LRD_ST_INIT: begin
            if (reset_seen) begin
               next_state = LRD_ST_RESET;
            end else if (link_ready_s) begin
               next_state = LRD_ST_NORMAL;
            end
         end
         LRD_ST_NORMAL: begin
            if (reset_seen) begin
               next_state = LRD_ST_RESET;
            end
         end
         LRD_ST_RESET: begin
            if (disable_seen) begin
               next_state = LRD_ST_DISABLED;
            end else if (pwr_stat_s && !link_ready_s) begin
               // Waiting for the stale ready level to clear avoids a false completion.
               next_state = LRD_ST_INIT;
            end
         end
         default: begin
            next_state = LRD_ST_DISABLED;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= LRD_ST_DISABLED;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wake_cnt <= '0;
      end else if (state == LRD_ST_WAKE) begin
         wake_cnt <= wake_cnt + `LRD_WAKE_W'h1;
      end else begin
         wake_cnt <= '0;
      end
   end

   // Levels handed to the link side; both change only with the state.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         clock_run <= 1'b0;
         iface_on <= 1'b0;
      end else begin
         clock_run <= next_state != LRD_ST_DISABLED && next_state != LRD_ST_WAKE;
         iface_on <= next_state == LRD_ST_INIT || next_state == LRD_ST_NORMAL;
      end
   end

   // Low power is left through the wake delay, or directly when ports_active rises while disabled.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         low_power <= 1'b0;
      end else begin
         low_power <= (next_state == LRD_ST_DISABLED && !ports_active) || next_state == LRD_ST_WAKE;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         iface_ready <= 1'b0;
         iface_reset <= 1'b0;
         iface_disabled <= 1'b1;
      end else begin
         iface_ready <= next_state == LRD_ST_NORMAL;
         iface_reset <= next_state == LRD_ST_RESET;
         iface_disabled <= next_state == LRD_ST_DISABLED || next_state == LRD_ST_WAKE;
      end
   end

   // Status raised while the interface is down is thrown away, never queued.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         status_discard <= 1'b0;
      end else begin
         status_discard <= status_pending && state != LRD_ST_NORMAL;
      end
   end

   // ---------------------------------------------------------------
   // Link clock domain: pins, interface clock and initialisation.
   // ---------------------------------------------------------------

   lrd_link_e lstate;
   logic nrst_l;
   logic iso_l;
   logic on_l;
   logic run_l;
   logic req_l;
   logic [2:0] init_cnt;
   logic tick;
   logic drive_hold;

   lrd_sync u_sync_nrst (
      .clk(link_clk),
      .din(nrst),
      .dout(nrst_l)
   );

   lrd_sync u_sync_iso (
      .clk(link_clk),
      .din(iso_mode),
      .dout(iso_l)
   );

   lrd_sync u_sync_on (
      .clk(link_clk),
      .din(iface_on),
      .dout(on_l)
   );

   lrd_sync u_sync_run (
      .clk(link_clk),
      .din(clock_run),
      .dout(run_l)
   );

   lrd_sync u_sync_req (
      .clk(link_clk),
      .din(link_request_line),
      .dout(req_l)
   );

   // The interface clock is link_clk halved; it starts from low for half a cycle.
   always_ff @(posedge link_clk) begin
      if (!nrst_l || !run_l) begin
         interface_clock_out <= 1'b0;
      end else begin
         interface_clock_out <= !interface_clock_out;
      end
   end

   // Differentiated mode floats the stopped clock; the other mode holds it low.
   always_ff @(posedge link_clk) begin
      if (!nrst_l) begin
         interface_clock_oe <= 1'b0;
      end else begin
         interface_clock_oe <= iso_l || run_l;
      end
   end

   // Pin updates land on the falling edge of the interface clock, ahead of its rising edge.
   assign tick = interface_clock_out;

   always_ff @(posedge link_clk) begin
      if (!nrst_l || !on_l) begin
         lstate <= LRD_LK_OFF;
         init_cnt <= 3'h0;
      end else if (tick) begin
         case (lstate)
            LRD_LK_OFF: begin
               lstate <= LRD_LK_INIT;
               init_cnt <= 3'h0;
            end
            LRD_LK_INIT: begin
               init_cnt <= init_cnt + 3'h1;
               if (init_cnt == `LRD_INIT_LAST - 3'h1) begin
                  lstate <= LRD_LK_RECV;
               end
            end
            LRD_LK_RECV: begin
               lstate <= LRD_LK_RUN;
            end
            LRD_LK_RUN: begin
               lstate <= LRD_LK_RUN;
            end
            default: begin
               lstate <= LRD_LK_OFF;
            end
         endcase
      end
   end

   // Values on control and data; zero in every state but receive.
   always_ff @(posedge link_clk) begin
      if (!nrst_l || !on_l) begin
         control_lines_out <= `LRD_CONTROL_IDLE;
         data_out <= `LRD_DATA_ZERO;
      end else if (tick) begin
         if (lstate == LRD_LK_INIT && init_cnt == `LRD_INIT_LAST - 3'h1) begin
            control_lines_out <= `LRD_CONTROL_RECEIVE;
            data_out <= `LRD_DATA_ON;
         end else begin
            control_lines_out <= `LRD_CONTROL_IDLE;
            data_out <= `LRD_DATA_ZERO;
         end
      end
   end

   // A nonzero value is driven to zero for one more cycle before letting go.
   assign drive_hold = control_lines_oe && (control_lines_out != `LRD_CONTROL_IDLE || data_out != `LRD_DATA_ZERO);

   always_ff @(posedge link_clk) begin
      if (!nrst_l) begin
         control_lines_oe <= 1'b0;
         data_oe <= 1'b0;
      end else if (!on_l) begin
         control_lines_oe <= iso_l || drive_hold;
         data_oe <= iso_l || drive_hold;
      end else if (tick) begin
         case (lstate)
            LRD_LK_OFF: begin
               control_lines_oe <= 1'b1;
               data_oe <= 1'b1;
            end
            LRD_LK_INIT: begin
               // Differentiated mode drives only the first cycle and the receive cycle.
               control_lines_oe <= iso_l || init_cnt == `LRD_INIT_LAST - 3'h1;
               data_oe <= iso_l || init_cnt == `LRD_INIT_LAST - 3'h1;
            end
            LRD_LK_RECV, LRD_LK_RUN: begin
               control_lines_oe <= 1'b1;
               data_oe <= 1'b1;
            end
            default: begin
               control_lines_oe <= iso_l;
               data_oe <= iso_l;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk) begin
      if (!nrst_l) begin
         link_ready <= 1'b0;
      end else begin
         link_ready <= on_l && lstate == LRD_LK_RUN;
      end
   end

   // Requests count only in normal operation; leaving it cancels what is pending.
   always_ff @(posedge link_clk) begin
      if (!nrst_l) begin
         link_request_seen <= 1'b0;
         request_cancel <= 1'b0;
      end else begin
         link_request_seen <= req_l && on_l && lstate == LRD_LK_RUN;
         request_cancel <= link_ready && !(on_l && lstate == LRD_LK_RUN);
      end
   end

endmodule : lrd_top

// file: bench/lrd_checker_asserts.sv
// Port assertions for the link interface reset and disable block.
// Assumes clk at 125 MHz and the block's synchronous active-low reset.
`timescale 1ns/1ps
module lrd_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Link pins
   input wire logic link_power_status,
   input wire logic iso_mode,
   input wire logic [1:0] control_lines_out,
   input wire logic control_lines_oe,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic interface_clock_out,
   input wire logic interface_clock_oe,
   // Core side
   input wire logic ports_active,
   input wire logic status_pending,
   input wire logic iface_ready,
   input wire logic iface_reset,
   input wire logic iface_disabled,
   input wire logic low_power,
   input wire logic status_discard,
   input wire logic link_request_seen
);
   // Counters saturate so a long disable never wraps into a false pass.
   logic [11:0] low_cnt;
   logic [6:0] off_cnt;
   logic [6:0] dis_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clk) begin
      if (!nrst || link_power_status) low_cnt <= 12'h000;
      else if (low_cnt != 12'hFFF) low_cnt <= low_cnt + 12'h001;
   end
   always_ff @(posedge clk) begin
      if (!nrst || !iface_reset || link_power_status) off_cnt <= 7'h00;
      else if (off_cnt != 7'h7F) off_cnt <= off_cnt + 7'h01;
   end
   always_ff @(posedge clk) begin
      if (!nrst || !iface_disabled || link_power_status) dis_cnt <= 7'h00;
      else if (dis_cnt != 7'h7F) dis_cnt <= dis_cnt + 7'h01;
   end
   sequence reassert_s;
      (iface_reset || iface_disabled) && $rose(link_power_status);
   endsequence
   sequence wake_fast_s;
      iface_disabled && !low_power && $rose(link_power_status);
   endsequence
   reset_deadline_a: assert property (low_cnt >= 12'h150 |-> !iface_ready && (iface_reset || iface_disabled))
      else $error("interface not reset in time");
   disable_deadline_a: assert property (low_cnt >= 12'hCC0 |-> iface_disabled)
      else $error("interface not disabled in time");
   pulse_tolerance_a: assert property ($rose(iface_reset) |-> low_cnt > 12'h145)
      else $error("reset taken on a legal low phase");
   reset_pins_a: assert property (off_cnt >= 7'h40 |-> control_lines_out == 2'h0 && data_out == 8'h00
      && !link_request_seen)
      else $error("link pins or request active in reset");
   reset_drive_a: assert property (off_cnt >= 7'h40 |-> control_lines_oe == iso_mode && data_oe == iso_mode)
      else $error("wrong drive enables in reset");
   clock_stop_a: assert property (dis_cnt >= 7'h40 |-> !interface_clock_out && interface_clock_oe == iso_mode)
      else $error("interface clock not stopped");
   low_power_a: assert property ((iface_disabled && !ports_active && !link_power_status) [*2] |-> low_power)
      else $error("low power not entered");
   discard_a: assert property ((status_pending && (iface_reset || iface_disabled)) [*2] |-> status_discard)
      else $error("status kept while not operational");
   hw_reset_a: assert property ($rose(nrst) |-> iface_disabled && !iface_ready)
      else $error("not disabled after hardware reset");
   fast_restart_a: assert property (wake_fast_s |-> ##[1:60] $changed(interface_clock_out))
      else $error("interface clock slow to restart");
   restore_a: assert property (reassert_s |-> ##[1:600] iface_ready)
      else $error("no return to normal operation");
endmodule : lrd_checker

bind lrd_top lrd_checker chk_u (.clk(clk), .nrst(nrst), .link_power_status(link_power_status),
   .iso_mode(iso_mode), .control_lines_out(control_lines_out), .control_lines_oe(control_lines_oe),
   .data_out(data_out), .data_oe(data_oe), .interface_clock_out(interface_clock_out),
   .interface_clock_oe(interface_clock_oe), .ports_active(ports_active), .status_pending(status_pending),
   .iface_ready(iface_ready), .iface_reset(iface_reset), .iface_disabled(iface_disabled),
   .low_power(low_power), .status_discard(status_discard), .link_request_seen(link_request_seen));

// file: bench/lrd_link_ctrl.sv
// Link-layer controller model driving the power status and request lines.
// Assumes the bench keeps low_len under 325 cycles and steps it on falling clk edges.
`timescale 1ns/1ps
module lrd_link_ctrl (
   // Clock
   input wire logic clk,
   // Bench controls
   input wire logic active,
   input wire logic pulsed,
   input wire logic [8:0] low_len,
   input wire logic req_in,
   // Lines to the physical layer
   output logic link_power_status,
   output logic link_request_line
);
   logic [8:0] cnt = 9'h000;
   logic [8:0] phase = 9'h000;
   initial link_power_status = 1'b0;
   initial link_request_line = 1'b0;
   // Equal high and low phases hold the duty cycle at one half.
   // Lines move on the rising edge by non-blocking assignment, so falling-edge bench controls never race them.
   always @(posedge clk) begin
      if (!active) begin
         link_power_status <= 1'b0;
         cnt <= 9'h000;
      end else if (!pulsed) begin
         link_power_status <= 1'b1;
      end else if (cnt == 9'h000) begin
         link_power_status <= !link_power_status;
         cnt <= link_power_status ? phase : low_len;
         if (!link_power_status) phase <= low_len;
      end else begin
         cnt <= cnt - 9'h001;
      end
   end
   always @(posedge clk) link_request_line <= active && req_in;
endmodule : lrd_link_ctrl

// file: bench/lrd_top_tb.sv
// Self-checking bench for the link interface reset and disable block.
// Assumes the partner model in lrd_link_ctrl.sv and the bound checker.
`timescale 1ns/1ps
module lrd_top_tb;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic nrst = 1'b0;
   logic iso_mode = 1'b0;
   logic ports_active = 1'b1;
   logic status_pending = 1'b0;
   logic active = 1'b0;
   logic pulsed = 1'b1;
   logic req_in = 1'b0;
   logic [8:0] low_len = 9'h064;
   logic [16:0] seed = 17'h13DF1;
   logic link_power_status, link_request_line, control_lines_oe, data_oe;
   logic interface_clock_out, interface_clock_oe, iface_ready, iface_reset, iface_disabled;
   logic low_power, status_discard, link_request_seen, p_rdy, p_rst, p_dis;
   logic request_cancel, p_can, p_recv;
   logic [1:0] control_lines_out;
   logic [7:0] data_out;
   logic [1:0] notes[$];
   int miscompares = 0;
   int checked = 0;
   int cancels = 0;
   int recvs = 0;
   always #4 clk = ~clk;
   initial begin
      #1.5;
      forever #40 link_clk = ~link_clk;
   end
   lrd_link_ctrl prt_u (.clk(clk), .active(active), .pulsed(pulsed), .low_len(low_len), .req_in(req_in),
      .link_power_status(link_power_status), .link_request_line(link_request_line));
   lrd_top #(.WAKE_CYCLES(50)) dut_u (.clk(clk), .link_clk(link_clk), .nrst(nrst),
      .link_power_status(link_power_status), .link_request_line(link_request_line), .iso_mode(iso_mode),
      .control_lines_out(control_lines_out), .control_lines_oe(control_lines_oe), .data_out(data_out),
      .data_oe(data_oe), .interface_clock_out(interface_clock_out), .interface_clock_oe(interface_clock_oe),
      .ports_active(ports_active), .status_pending(status_pending), .iface_ready(iface_ready),
      .iface_reset(iface_reset), .iface_disabled(iface_disabled), .low_power(low_power),
      .status_discard(status_discard), .link_request_seen(link_request_seen), .request_cancel(request_cancel));
   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr_next
   task automatic summarize();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task automatic note(input logic [1:0] seen);
      logic [1:0] exp;
      exp = (notes.size() == 0) ? 2'h0 : notes.pop_front();
      check("event", {6'h00, seen}, {6'h00, exp});
   endtask : note
   // A bound that runs out is counted and ends the run at once.
   task automatic wait_for(input int which, input int bound);
      logic [2:0] f;
      for (int n = 0; n < bound; n++) begin
         @(negedge clk);
         f = {iface_disabled, iface_reset, iface_ready};
         if (f[which] === 1'b1) return;
      end
      miscompares++;
      summarize();
   endtask : wait_for
   task automatic run_pulsed(input int n);
      for (int i = 0; i < n; i++) begin
         seed = lfsr_next(seed);
         low_len = 9'h064 + {2'h0, seed[6:0]};
         req_in = seed[8];
         status_pending = seed[9];
         ports_active = seed[10];
         repeat (64) @(negedge clk);
         check("request", {7'h00, link_request_seen}, {7'h00, req_in});
         check("discard", {7'h00, status_discard}, 8'h00);
         check("low power", {7'h00, low_power}, 8'h00);
      end
   endtask : run_pulsed
   always @(negedge clk) begin
      if (nrst === 1'b1) begin
         if (iface_ready === 1'b1 && p_rdy !== 1'b1) note(2'h1);
         if (iface_reset === 1'b1 && p_rst !== 1'b1) note(2'h2);
         if (iface_disabled === 1'b1 && p_dis !== 1'b1) note(2'h3);
         if (request_cancel === 1'b1 && p_can !== 1'b1) cancels++;
         if (control_lines_out === 2'h2 && p_recv !== 1'b1) recvs++;
      end
      p_can = request_cancel;
      p_recv = (control_lines_out === 2'h2);
      p_rdy = iface_ready;
      p_rst = iface_reset;
      p_dis = iface_disabled;
   end
   initial begin
      for (int m = 0; m < 2; m++) begin
         @(negedge clk);
         nrst = 1'b0;
         active = 1'b0;
         pulsed = 1'b1;
         status_pending = 1'b0;
         iso_mode = m[0];
         ports_active = !m[0];
         // The link side sees reset through a synchroniser, so hold it for several link clocks.
         repeat (48) @(negedge clk);
         nrst = 1'b1;
         @(negedge clk);
         check("disabled", {7'h00, iface_disabled}, 8'h01);
         check("clock", {7'h00, interface_clock_out}, 8'h00);
         notes.push_back(2'h1);
         active = 1'b1;
         wait_for(0, 2000);
         run_pulsed(40);
         check("ready", {7'h00, iface_ready}, 8'h01);
         notes.push_back(2'h2);
         active = 1'b0;
         status_pending = 1'b1;
         ports_active = !m[0];
         wait_for(1, 400);
         repeat (100) @(negedge clk);
         check("control", {6'h00, control_lines_out}, 8'h00);
         check("data", data_out, 8'h00);
         check("control oe", {7'h00, control_lines_oe}, {7'h00, m[0]});
         check("discard", {7'h00, status_discard}, 8'h01);
         check("cancel", 8'(cancels), 8'(2 * m + 1));
         notes.push_back(2'h1);
         pulsed = 1'b0;
         active = 1'b1;
         wait_for(0, 2000);
         notes.push_back(2'h2);
         notes.push_back(2'h3);
         active = 1'b0;
         wait_for(2, 3600);
         repeat (100) @(negedge clk);
         check("clock oe", {7'h00, interface_clock_oe}, {7'h00, m[0]});
         check("clock", {7'h00, interface_clock_out}, 8'h00);
         check("low power", {7'h00, low_power}, {7'h00, m[0]});
         check("cancel", 8'(cancels), 8'(2 * m + 2));
         notes.push_back(2'h1);
         active = 1'b1;
         wait_for(0, 2000);
         repeat (4) @(negedge clk);
         check("discard", {7'h00, status_discard}, 8'h00);
         check("receive", 8'(recvs), 8'(3 * m + 3));
      end
      repeat (8) @(negedge clk);
      check("notes left", 8'(notes.size()), 8'h00);
      summarize();
   end
endmodule : lrd_top_tb
